/* File: hw/protect_pkg.sv */
/*
 Constants for the per-output protection, status and settings store logic:
 command codes, error codes, settings word layout, status bit positions.
 Assumes a command decoder outside that turns bus messages into one-cycle commands.
*/
// Notes on behaviour
// - Voltage re-arm while excess voltage persists trips that output again.
// - Positive constant current with current trip enabled drives voltage down, disables output.
// - Current trip enable set by 1, cleared by 0; query answers 0 or 1.
// - Re-arm commands re-enable the output but leave fault contents alone.
// - Eleven slots 0 to 10, each holding all settings of every output.
// - Slots 0 to 3 take one save per power cycle; more give error 30.
// - Every slot also keeps delay and mask, loaded only on recall of slot 0; power-up loads from slot 0.
// - Power cycle sets slots 4 to 10 to 0 V, 10 mA, max trip level, high ranges.
// - Save copies present settings of all outputs into slot 0 to 10.
// - Recall applies settings output by output in ascending order from output 1.
// - Recall of slot beyond 10 is not executed and raises error 5.
// - Clear command restores all parameters to power-on values.
// - Clear keeps slots and listener state, and clears the power-up flag.
// - Eight-bit status per output; each bit is 1 exactly while its condition holds.
// - Bits 0..7: const volt, pos current, neg limit, volt trip, heat, unreg, current trip, coupled.
// - Status query returns the weighted sum of set bits, bit n weighs 2**n.
// - High to low range switch clamps setting to low maximum and sets coupled bit; here only a recalled low-range value above the maximum is clamped and flagged.
// - Status contents follow only internal state; commands never write them.
package protect_pkg;
   localparam int NUM_CHAN   = 4;
   localparam int NUM_SLOTS  = 11;
   localparam int NV_SLOTS   = 4;
   localparam int VOLT_W     = 12;
   localparam int CURR_W     = 12;
   localparam int OVL_W      = 12;
   localparam int SET_W      = VOLT_W + 1 + CURR_W + 1 + OVL_W;
   localparam int DM_W       = 16;
   // Settings word fields, low to high
   localparam int F_VOLT     = 0;
   localparam int F_VRANGE   = 12;
   localparam int F_CURR     = 13;
   localparam int F_IRANGE   = 25;
   localparam int F_OVL      = 26;
   // Command codes
   localparam logic [3:0] CMD_SAVE    = 4'h1;
   localparam logic [3:0] CMD_LOAD    = 4'h2;
   localparam logic [3:0] CMD_RESTORE = 4'h3;
   localparam logic [3:0] CMD_VREARM  = 4'h4;
   localparam logic [3:0] CMD_CREARM  = 4'h5;
   localparam logic [3:0] CMD_CTEN    = 4'h6;
   localparam logic [3:0] CMD_CTEN_Q  = 4'h7;
   localparam logic [3:0] CMD_STAT_Q  = 4'h8;
   // Error codes
   localparam logic [7:0] ERR_RANGE   = 8'h05;
   localparam logic [7:0] ERR_STORE   = 8'h1e;
   // Status bit positions
   localparam int B_CVOLT = 0, B_PCC = 1, B_NCC = 2, B_VTRIP = 3;
   localparam int B_HEAT = 4, B_UNREG = 5, B_CTRIP = 6, B_COUPLED = 7;
   // Volatile slot defaults and low range limits (codes, plain defaults)
   localparam logic [VOLT_W-1:0] VOLT_ZERO    = 12'h000;
   localparam logic [CURR_W-1:0] CURR_10MA    = 12'h0a0;
   localparam logic [OVL_W-1:0]  OVL_MAX      = 12'hfff;
   localparam logic [VOLT_W-1:0] VOLT_LOW_MAX = 12'h23d;
   localparam logic [CURR_W-1:0] CURR_LOW_MAX = 12'h07b;
   localparam logic              RANGE_HIGH   = 1'b1;
   localparam logic [SET_W-1:0]  SET_DEFAULT  = {OVL_MAX, RANGE_HIGH, CURR_10MA, RANGE_HIGH, VOLT_ZERO};
   localparam logic [3:0]        LAST_SLOT    = 4'ha;
endpackage

/* File: hw/trip_latch.sv */
/*
 Per-output trip latches for excess voltage and excess current.
 Assumes the trip sense inputs are synchronous levels from the analog side.
*/
`timescale 1ns/10ps
module trip_latch (
   input  wire logic clock_i,       // System clock
   input  wire logic rst_i,         // Sync reset, high
   input  wire logic over_volt_i,   // Excess voltage sensed
   input  wire logic pos_cc_i,      // Positive constant current
   input  wire logic ctrip_en_i,    // Current trip enabled
   input  wire logic vrearm_i,      // Voltage re-arm pulse
   input  wire logic crearm_i,      // Current re-arm pulse
   output logic      vtrip_o,       // Voltage trip latched
   output logic      ctrip_o        // Current trip latched
);
   logic vtrip_r;
   logic ctrip_r;
   logic vtrip_nxt;
   logic ctrip_nxt;
   wire  ccause = ctrip_en_i & pos_cc_i;

   // Cause wins over re-arm, so a re-arm into a live fault trips again
   assign vtrip_nxt = over_volt_i | (vtrip_r & ~vrearm_i);
   assign ctrip_nxt = ccause | (ctrip_r & ~crearm_i);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         vtrip_r <= 1'b0;
         ctrip_r <= 1'b0;
      end else begin
         vtrip_r <= vtrip_nxt;
         ctrip_r <= ctrip_nxt;
      end
   end
   assign vtrip_o = vtrip_r;
   assign ctrip_o = ctrip_r;

   a_vtrip_holds: assert property (@(posedge clock_i) disable iff (rst_i)
      vtrip_r && !vrearm_i |=> vtrip_r) else $error("voltage trip dropped without re-arm");
   a_vrearm_live: assert property (@(posedge clock_i) disable iff (rst_i)
      vrearm_i && over_volt_i |=> vtrip_r) else $error("re-arm cleared a live overvoltage");
   a_ctrip_sets: assert property (@(posedge clock_i) disable iff (rst_i)
      ctrip_en_i && pos_cc_i |=> ctrip_r) else $error("current trip not taken");
endmodule // trip_latch

/* File: hw/slot_store.sv */
/*
 Settings slot array: eleven rows, each the settings of every output plus
 delay and mask. Slots below the volatile boundary survive reset.
 Assumes reset stands for a power cycle.
*/
`timescale 1ns/10ps
module slot_store #(
   parameter int ROW_W = protect_pkg::NUM_CHAN * protect_pkg::SET_W + protect_pkg::DM_W
) (
   input  wire logic             clock_i,  // System clock
   input  wire logic             rst_i,    // Sync reset, high
   input  wire logic             wr_i,     // Write row
   input  wire logic [3:0]       waddr_i,  // Write slot
   input  wire logic [ROW_W-1:0] wdata_i,  // Row to write
   input  wire logic [3:0]       raddr_i,  // Read slot
   output logic      [ROW_W-1:0] rdata_o   // Registered row
);
   logic [ROW_W-1:0] mem_r [protect_pkg::NUM_SLOTS];
   logic [ROW_W-1:0] rdata_r;
   localparam logic [ROW_W-1:0] ROW_DEFAULT =
      {{protect_pkg::DM_W{1'b0}}, {protect_pkg::NUM_CHAN{protect_pkg::SET_DEFAULT}}};

   // Non-volatile rows are never touched by reset; volatile rows are rewritten
   always_ff @(posedge clock_i) begin
      for (int s = protect_pkg::NV_SLOTS; s < protect_pkg::NUM_SLOTS; s++) begin
         if (rst_i) begin
            mem_r[s] <= ROW_DEFAULT;
         end else if (wr_i && waddr_i == 4'(s)) begin
            mem_r[s] <= wdata_i;
         end
      end
      for (int s = 0; s < protect_pkg::NV_SLOTS; s++) begin
         if (!rst_i && wr_i && waddr_i == 4'(s)) begin
            mem_r[s] <= wdata_i;
         end
      end
   end

   // One-cycle read latency
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= mem_r[raddr_i];
      end
   end
   assign rdata_o = rdata_r;
endmodule // slot_store

/* File: hw/output_protect_status_store.sv */
/*
 Top of the per-output control: command interpreter for trip re-arm, current
 trip enable, save/recall of settings slots, clear, and condition status query.
 Assumes one-cycle commands from a bus message decoder and synchronous analog
 mode levels; the user of apply_* holds the live settings of each output.
*/
`timescale 1ns/10ps
module output_protect_status_store #(
   parameter int NCH = protect_pkg::NUM_CHAN
) (
   input  wire logic                           clock_i,         // 125 MHz clock
   input  wire logic                           rst_i,           // Sync reset, power cycle
   input  wire logic                           cmd_valid_i,     // Command strobe
   input  wire logic [3:0]                     cmd_code_i,      // Command code
   input  wire logic [1:0]                     cmd_chan_i,      // Output index, 0 = output 1
   input  wire logic [3:0]                     cmd_arg_i,       // Slot or enable argument
   input  wire logic [NCH*protect_pkg::SET_W-1:0] set_word_i,   // Present settings, all outputs
   input  wire logic [protect_pkg::DM_W-1:0]   delay_mask_i,    // Present delay and mask
   input  wire logic [NCH-1:0]                 cv_i,            // Constant voltage mode
   input  wire logic [NCH-1:0]                 pos_cc_i,        // Positive constant current
   input  wire logic [NCH-1:0]                 neg_cc_i,        // Negative current limit
   input  wire logic [NCH-1:0]                 over_volt_i,     // Excess voltage sensed
   input  wire logic [NCH-1:0]                 heat_i,          // Overtemperature tripped
   input  wire logic [NCH-1:0]                 unreg_i,         // Unregulated
   output logic                                reply_valid_o,   // Query reply strobe
   output logic [7:0]                          reply_data_o,    // Query reply value
   output logic                                error_valid_o,   // Error strobe
   output logic [7:0]                          error_code_o,    // Error code
   output logic                                apply_valid_o,   // Settings apply strobe
   output logic [1:0]                          apply_chan_o,    // Output being set
   output logic [protect_pkg::SET_W-1:0]       apply_word_o,    // Settings to apply
   output logic                                dm_valid_o,      // Delay/mask load strobe
   output logic [protect_pkg::DM_W-1:0]        delay_mask_o,    // Delay and mask to load
   output logic [NCH-1:0]                      out_enable_o,    // Output enabled
   output logic [NCH-1:0]                      down_prog_o,     // Drive voltage down
   output logic [NCH*8-1:0]                    status_o,        // Condition status, all outputs
   output logic                                powerup_flag_o,  // Power-on flag
   output logic                                busy_o           // Recall in progress
);
   localparam int SW  = protect_pkg::SET_W;
   localparam int ROW = NCH * SW + protect_pkg::DM_W;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FETCH = 3'b010,
      ST_APPLY = 3'b100
   } recall_state_e;

   recall_state_e           state_r, state_nxt;
   logic                    busy_r;
   logic [1:0]              chan_r;
   logic [3:0]              rslot_r;
   logic [NCH-1:0]          ctrip_en_r;
   logic [NCH-1:0]          coupled_r;
   logic [NCH-1:0]          vtrip_w;
   logic [NCH-1:0]          ctrip_w;
   logic [NCH*8-1:0]        status_r;
   logic [protect_pkg::NV_SLOTS-1:0] saved_r;
   logic                    reply_valid_r, error_valid_r, apply_valid_r, dm_valid_r;
   logic [7:0]              reply_data_r, error_code_r;
   logic [1:0]              apply_chan_r;
   logic [SW-1:0]           apply_word_r;
   logic [protect_pkg::DM_W-1:0] dm_r;
   logic                    pwr_flag_r;
   logic                    boot_r;
   logic [ROW-1:0]          row_w;
   logic [7:0]              stat_sel_w;

   // Command decode; commands are ignored while a recall runs
   wire take      = cmd_valid_i & (state_r == ST_IDLE) & ~boot_r;
   wire chan_ok   = {30'h0, cmd_chan_i} < NCH;
   wire slot_ok   = cmd_arg_i <= protect_pkg::LAST_SLOT;
   wire is_save   = take & (cmd_code_i == protect_pkg::CMD_SAVE);
   wire is_load   = take & (cmd_code_i == protect_pkg::CMD_LOAD);
   wire is_restore = take & (cmd_code_i == protect_pkg::CMD_RESTORE);
   wire ch_cmd    = take & chan_ok;
   wire is_vrearm = ch_cmd & (cmd_code_i == protect_pkg::CMD_VREARM);
   wire is_crearm = ch_cmd & (cmd_code_i == protect_pkg::CMD_CREARM);
   wire is_cten   = ch_cmd & (cmd_code_i == protect_pkg::CMD_CTEN);
   wire is_ctenq  = ch_cmd & (cmd_code_i == protect_pkg::CMD_CTEN_Q);
   wire is_statq  = ch_cmd & (cmd_code_i == protect_pkg::CMD_STAT_Q);
   wire chan_cmd  = (cmd_code_i >= protect_pkg::CMD_VREARM) && (cmd_code_i <= protect_pkg::CMD_STAT_Q);
   wire bad_chan  = take & chan_cmd & ~chan_ok;
   wire nv_slot   = cmd_arg_i < 4'(protect_pkg::NV_SLOTS);
   wire nv_used   = nv_slot & saved_r[cmd_arg_i[1:0]];
   wire save_ok   = is_save & slot_ok & ~nv_used;
   wire load_ok   = is_load & slot_ok;
   wire bad_range = ((is_save | is_load) & ~slot_ok) | bad_chan;
   wire bad_store = is_save & slot_ok & nv_used;
   wire start_recall = load_ok | is_restore | boot_r;
   wire [3:0] start_slot = load_ok ? cmd_arg_i : 4'h0;

   // Per-output trip latches and status bit assembly
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_chan
         trip_latch u_trip (
            .clock_i     (clock_i),
            .rst_i       (rst_i),
            .over_volt_i (over_volt_i[g]),
            .pos_cc_i    (pos_cc_i[g]),
            .ctrip_en_i  (ctrip_en_r[g]),
            .vrearm_i    (is_vrearm && cmd_chan_i == 2'(g)),
            .crearm_i    (is_crearm && cmd_chan_i == 2'(g)),
            .vtrip_o     (vtrip_w[g]),
            .ctrip_o     (ctrip_w[g])
         );
         // Only live internal state feeds the status bits
         always_ff @(posedge clock_i) begin
            if (rst_i) begin
               status_r[g*8 +: 8] <= 8'h00;
            end else begin
               status_r[g*8 +: 8] <= {coupled_r[g], ctrip_w[g], unreg_i[g], heat_i[g],
                                      vtrip_w[g], neg_cc_i[g], pos_cc_i[g], cv_i[g]};
            end
         end
      end
   endgenerate

   // Weighted value is the plain binary of the bit vector
   assign stat_sel_w = status_r[cmd_chan_i*8 +: 8];

   // Slot array; save captures every output plus delay and mask
   slot_store #(.ROW_W(ROW)) u_store (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .wr_i    (save_ok),
      .waddr_i (cmd_arg_i),
      .wdata_i ({delay_mask_i, set_word_i}),
      .raddr_i (rslot_r),
      .rdata_o (row_w)
   );

   // Range clamp on apply: low range caps the setting; coupling is flagged only when a value is capped
   wire [SW-1:0] raw_w   = row_w[chan_r*SW +: SW];
   wire [11:0]   rv_w    = raw_w[protect_pkg::F_VOLT +: 12];
   wire [11:0]   ri_w    = raw_w[protect_pkg::F_CURR +: 12];
   wire          vclamp  = ~raw_w[protect_pkg::F_VRANGE] & (rv_w > protect_pkg::VOLT_LOW_MAX);
   wire          iclamp  = ~raw_w[protect_pkg::F_IRANGE] & (ri_w > protect_pkg::CURR_LOW_MAX);
   wire [11:0]   v_fix   = vclamp ? protect_pkg::VOLT_LOW_MAX : rv_w;
   wire [11:0]   i_fix   = iclamp ? protect_pkg::CURR_LOW_MAX : ri_w;
   wire [SW-1:0] fix_w   = {raw_w[SW-1:protect_pkg::F_IRANGE], i_fix,
                            raw_w[protect_pkg::F_VRANGE], v_fix};
   wire          last_ch = chan_r == 2'(NCH - 1);

   // Recall sequencer: one output per cycle, output 1 first
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:  if (start_recall) state_nxt = ST_FETCH;
         ST_FETCH: state_nxt = ST_APPLY;
         ST_APPLY: if (last_ch) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         chan_r  <= 2'h0;
         rslot_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE && start_recall) begin
            rslot_r <= start_slot;
            chan_r  <= 2'h0;
         end else if (state_r == ST_APPLY) begin
            chan_r  <= chan_r + 2'h1;
         end
      end
   end

   // Apply strobe and coupled flags follow the sequencer
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         apply_valid_r <= 1'b0;
         apply_chan_r  <= 2'h0;
         apply_word_r  <= '0;
         dm_valid_r    <= 1'b0;
         dm_r          <= '0;
         coupled_r     <= '0;
      end else begin
         apply_valid_r <= state_r == ST_APPLY;
         dm_valid_r    <= 1'b0;
         if (state_r == ST_APPLY) begin
            apply_chan_r      <= chan_r;
            apply_word_r      <= fix_w;
            coupled_r[chan_r] <= vclamp | iclamp;
            if (chan_r == 2'h0 && rslot_r == 4'h0) begin
               dm_valid_r <= 1'b1;
               dm_r       <= row_w[ROW-1 -: protect_pkg::DM_W];
            end
         end
      end
   end

   // Boot load, power flag, enables and single-save tracking
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         boot_r     <= 1'b1;  // Load slot 0 once reset is released
         pwr_flag_r <= 1'b1;
         saved_r    <= '0;    // Each power cycle re-opens the non-volatile slots
         ctrip_en_r <= '0;
         busy_r     <= 1'b1;
      end else begin
         boot_r <= 1'b0;
         busy_r <= state_nxt != ST_IDLE; // Registered so the port comes from a flop
         if (is_restore) begin
            pwr_flag_r <= 1'b0;
            ctrip_en_r <= '0;
         end
         if (save_ok && nv_slot) begin
            saved_r[cmd_arg_i[1:0]] <= 1'b1;
         end
         if (is_cten) begin
            ctrip_en_r[cmd_chan_i] <= cmd_arg_i[0];
         end
      end
   end

   // Replies and errors, one cycle after the command
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         reply_valid_r <= 1'b0;
         reply_data_r  <= 8'h00;
         error_valid_r <= 1'b0;
         error_code_r  <= 8'h00;
      end else begin
         reply_valid_r <= is_statq | is_ctenq;
         if (is_statq) begin
            reply_data_r <= stat_sel_w;
         end else if (is_ctenq) begin
            reply_data_r <= {7'h00, ctrip_en_r[cmd_chan_i]};
         end
         error_valid_r <= bad_range | bad_store;
         if (bad_range) begin
            error_code_r <= protect_pkg::ERR_RANGE;
         end else if (bad_store) begin
            error_code_r <= protect_pkg::ERR_STORE;
         end
      end
   end

   // Enable and down-programming registered per output; fault store is not here
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         out_enable_o <= '0;
         down_prog_o  <= '0;
      end else begin
         out_enable_o <= ~(vtrip_w | ctrip_w);
         down_prog_o  <= ctrip_w;
      end
   end

   assign reply_valid_o  = reply_valid_r;
   assign reply_data_o   = reply_data_r;
   assign error_valid_o  = error_valid_r;
   assign error_code_o   = error_code_r;
   assign apply_valid_o  = apply_valid_r;
   assign apply_chan_o   = apply_chan_r;
   assign apply_word_o   = apply_word_r;
   assign dm_valid_o     = dm_valid_r;
   assign delay_mask_o   = dm_r;
   assign status_o       = status_r;
   assign powerup_flag_o = pwr_flag_r;
   assign busy_o         = busy_r;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_recall_start;
      state_r == ST_IDLE && load_ok;
   endsequence
   sequence s_outputs_in_order;
      ##3 apply_valid_r && apply_chan_r == 2'h0 ##1 apply_valid_r && apply_chan_r == 2'h1;
   endsequence

   a_recall_order: assert property (s_recall_start |-> s_outputs_in_order)
      else $error("recall did not apply outputs in ascending order");
   a_recall_range: assert property (is_load && cmd_arg_i > 4'ha |=> error_valid_r && error_code_r == 8'h05 ##1 !apply_valid_r)
      else $error("out-of-range recall not refused with code 5");
   a_store_limit: assert property (is_save && cmd_arg_i < 4'h4 && saved_r[cmd_arg_i[1:0]] |=> error_code_r == 8'h1e && error_valid_r)
      else $error("second save to non-volatile slot not refused");
   a_status_reply: assert property (is_statq |=> reply_valid_r && reply_data_r == $past(stat_sel_w))
      else $error("status reply does not match status bits");
   a_ovtrip_bit: assert property (vtrip_w[0] |=> status_r[3] && !out_enable_o[0])
      else $error("voltage trip not reported or output left on");
   a_clear_flag: assert property (is_restore |=> !pwr_flag_r ##1 busy_o)
      else $error("clear did not drop power flag and reload");
   a_cten_query: assert property (is_cten ##1 is_ctenq && $past(cmd_chan_i) == cmd_chan_i |=> reply_data_r == {7'h00, $past(cmd_arg_i[0], 2)})
      else $error("current trip enable query wrong");
   a_coupled_bit: assert property (state_r == ST_APPLY && vclamp |=> coupled_r[$past(chan_r)] ##1 status_r[$past(chan_r, 2)*8 + 7])
      else $error("clamp on apply did not set coupled bit");
endmodule // output_protect_status_store

/* File: verif/bus_ctl.sv */
/* Bus controller model: sends one-cycle commands to the block.
 Assumes the block ignores commands while busy. */
`timescale 1ns/10ps
module bus_ctl (
   input  wire logic clock_i, // Clock
   input  wire logic busy_i,  // Block busy
   output logic       valid_o, // Command strobe
   output logic [3:0] code_o,  // Command code
   output logic [1:0] chan_o,  // Output named
   output logic [3:0] arg_o    // Slot or enable
);
   initial {valid_o, code_o, chan_o, arg_o} = '0;
   // Waits for idle, one strobe; caller names channel and may re-arm while a trip cause is still live
   // No fault register here, so the advised read after a re-arm has nothing to clear
   task automatic send(input logic [3:0] c, input logic [1:0] ch, input logic [3:0] a);
      int n;
      n = 0;
      while (busy_i === 1'b1 && n < 99) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      @(posedge clock_i);
      valid_o <= 1'b1;
      code_o  <= c;
      chan_o  <= ch;
      arg_o   <= a;
      @(posedge clock_i);
      valid_o <= 1'b0;
      #1;
   endtask
endmodule // bus_ctl

/* File: verif/output_protect_status_store_test.sv */
/* Self-checking bench for the protection, status and slot store block.
 Assumes the hand-over timing; commands come from the bus controller model. */
`timescale 1ns/10ps
module output_protect_status_store_test;
   localparam int W = protect_pkg::SET_W;
   logic           clock_i = 1'b0, rst_i = 1'b1, cmd_valid_i, reply_valid_o, error_valid_o;
   logic           apply_valid_o, dm_valid_o, powerup_flag_o, busy_o;
   logic [3:0]     cmd_code_i, cmd_arg_i, out_enable_o, down_prog_o, used = '0;
   logic [1:0]     cmd_chan_i, apply_chan_o;
   logic [7:0]     reply_data_o, error_code_o;
   logic [4*W-1:0] set_word_i = '0, mem [11];
   logic [15:0]    delay_mask_i = '0, delay_mask_o, dmem;
   logic [W-1:0]   apply_word_o;
   logic [31:0]    status_o;
   logic [3:0]     lv [6] = '{default: '0};
   int             failures = 0, samples_checked = 0;
   // 125 MHz clock
   always #4 clock_i = ~clock_i;
   bus_ctl bus_ctl_inst (.clock_i, .busy_i(busy_o), .valid_o(cmd_valid_i), .code_o(cmd_code_i),
      .chan_o(cmd_chan_i), .arg_o(cmd_arg_i));
   output_protect_status_store output_protect_status_store_inst (.clock_i, .rst_i, .cmd_valid_i,
      .cmd_code_i, .cmd_chan_i, .cmd_arg_i, .set_word_i, .delay_mask_i, .cv_i(lv[0]), .pos_cc_i(lv[1]),
      .neg_cc_i(lv[2]), .over_volt_i(lv[3]), .heat_i(lv[4]), .unreg_i(lv[5]), .reply_valid_o,
      .reply_data_o, .error_valid_o, .error_code_o, .apply_valid_o, .apply_chan_o, .apply_word_o,
      .dm_valid_o, .delay_mask_o, .out_enable_o, .down_prog_o, .status_o, .powerup_flag_o, .busy_o);
   task automatic cmp(string nm, logic [63:0] e, logic [63:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic settle;
      repeat (4) @(posedge clock_i);
      #1;
   endtask
   // One command; error strobe against the model's verdict
   task automatic cmd(logic [3:0] c, logic [1:0] ch, logic [3:0] a, logic [7:0] e);
      bus_ctl_inst.send(c, ch, a);
      cmp("error_valid", e != 8'h00, error_valid_o);
      if (e != 8'h00) cmp("error_code", e, error_code_o);
   endtask
   task automatic query(logic [3:0] c, logic [1:0] ch, logic [7:0] e);
      cmd(c, ch, 4'h0, 8'h00);
      cmp("reply_valid", 1, reply_valid_o);
      cmp("reply_data", e, reply_data_o);
   endtask
   // Save model: slots 0..3 once per power cycle; high ranges so no clamp
   task automatic save(int s);
      logic [159:0] t;
      logic [7:0]   e;
      t = {$urandom, $urandom, $urandom, $urandom, $urandom};
      for (int i = 0; i < 4; i++) t[i*W+12] = 1'b1;
      for (int i = 0; i < 4; i++) t[i*W+25] = 1'b1;
      e = (s > 10) ? 8'h05 : (s < 4 && used[s]) ? 8'h1e : 8'h00;
      @(posedge clock_i);
      set_word_i <= t[4*W-1:0];
      delay_mask_i <= t[159:144];
      cmd(protect_pkg::CMD_SAVE, 2'd0, 4'(s), e);
      if (e == 8'h00) mem[s] = t[4*W-1:0];
      if (e == 8'h00 && s == 0) dmem = t[159:144];
      if (s < 4) used[s] = 1'b1;
   endtask
   // Recall applies outputs 0..3 in order
   task automatic chk_load(int s);
      int n;
      for (int i = 0; i < 4; i++) begin
         n = 0;
         do begin
            @(posedge clock_i);
            #1;
            n++;
         end while (apply_valid_o !== 1'b1 && n < 8);
         cmp("apply_chan", i, apply_chan_o);
         cmp("apply_word", mem[s][i*W+:W], apply_word_o);
         if (i == 0 && s == 0) cmp("dm_valid", 1, dm_valid_o);
         if (i == 0 && s == 0) cmp("delay_mask", dmem, delay_mask_o);
      end
   endtask
   // Main sequence; boot recall of unwritten slot 0 is not compared
   initial begin
      logic [7:0] r;
      void'($urandom(78));
      for (int s = 4; s < 11; s++) mem[s] = {4{protect_pkg::SET_DEFAULT}};
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      settle();
      cmp("powerup_flag", 1, powerup_flag_o);
      save(0);
      save(5);
      cmd(protect_pkg::CMD_RESTORE, 2'd0, 4'h0, 8'h00);
      chk_load(0);
      cmp("powerup_flag", 0, powerup_flag_o);
      save(0);
      save(3);
      save(11);
      cmd(protect_pkg::CMD_LOAD, 2'd0, 4'h5, 8'h00);
      chk_load(5);
      cmd(protect_pkg::CMD_LOAD, 2'd0, 4'h7, 8'h00);
      chk_load(7);
      cmd(protect_pkg::CMD_LOAD, 2'd0, 4'hc, 8'h05);
      cmd(protect_pkg::CMD_LOAD, 2'd0, 4'h3, 8'h00);
      chk_load(3);
      // Random modes on output 4, trip sense kept low
      for (int k = 0; k < 8; k++) begin
         r = 8'($urandom) & 8'h37;
         @(posedge clock_i);
         for (int b = 0; b < 6; b++) lv[b][3] <= r[b];
         settle();
         cmp("status", r, status_o[31:24]);
         query(protect_pkg::CMD_STAT_Q, 2'd3, r);
      end
      @(posedge clock_i);
      lv[3][0] <= 1'b1;
      settle();
      cmp("out_enable", 0, out_enable_o[0]);
      query(protect_pkg::CMD_STAT_Q, 2'd0, 8'h08);
      cmd(protect_pkg::CMD_VREARM, 2'd0, 4'h0, 8'h00);
      settle();
      cmp("out_enable", 0, out_enable_o[0]);
      @(posedge clock_i);
      lv[3][0] <= 1'b0;
      settle();
      cmd(protect_pkg::CMD_VREARM, 2'd0, 4'h0, 8'h00);
      settle();
      cmp("out_enable", 1, out_enable_o[0]);
      cmd(protect_pkg::CMD_CTEN, 2'd1, 4'h1, 8'h00);
      query(protect_pkg::CMD_CTEN_Q, 2'd1, 8'h01);
      @(posedge clock_i);
      lv[1][1] <= 1'b1;
      settle();
      cmp("down_prog", 1, down_prog_o[1]);
      cmp("out_enable", 0, out_enable_o[1]);
      query(protect_pkg::CMD_STAT_Q, 2'd1, 8'h42);
      cmd(protect_pkg::CMD_CTEN, 2'd1, 4'h0, 8'h00);
      query(protect_pkg::CMD_CTEN_Q, 2'd1, 8'h00);
      cmd(protect_pkg::CMD_CREARM, 2'd1, 4'h0, 8'h00);
      settle();
      cmp("out_enable", 1, out_enable_o[1]);
      query(protect_pkg::CMD_STAT_Q, 2'd1, 8'h02);
      complete_run();
   end
   // Run is under two hundred cycles; this cuts a hang short
   initial begin
      #200000;
      failures++;
      complete_run();
   end
endmodule // output_protect_status_store_test
